/* logic/rsw_defs.vh */
// rsw_defs.vh: register offsets, field positions and reset values for the relay safety watchdog
// assumes plain-port register access with word-wide data
`ifndef RSW_DEFS_VH
`define RSW_DEFS_VH
`define RSW_A_CTRL 4'h0
`define RSW_A_PRESET 4'h1
`define RSW_A_DIRECT 4'h2
`define RSW_A_WD_INTERVAL 4'h3
`define RSW_A_CMD 4'h4
`define RSW_A_AUX_DIR 4'h5
`define RSW_A_AUX_OUT 4'h6
`define RSW_A_AUX_IN 4'h7
`define RSW_A_STATUS 4'h8
`define RSW_A_SCAN_LEN 4'h9
`define RSW_A_SCAN_DATA 4'ha
`define RSW_A_WD_COUNT 4'hb
`define RSW_A_STAR 4'hc
// control bits
`define RSW_C_SHDN_EN 0
`define RSW_C_SHDN_SRC 1
`define RSW_C_WD_EN 2
`define RSW_C_WD_SRC 3
`define RSW_C_AUTO 4
`define RSW_C_CYCLIC 5
`define RSW_C_WD_DRIVE 6
`define RSW_C_SHDN_TLO 8
`define RSW_C_WD_TLO 12
`define RSW_C_WD_OLO 16
// command bits
`define RSW_K_WD_KICK 0
`define RSW_K_RECOVER 1
`define RSW_K_SCAN_START 2
`define RSW_K_SCAN_ABORT 3
`define RSW_K_SCAN_ADDR_CLR 4
// star trigger register
`define RSW_S_EN 0
// reset values
`define RSW_PRESET_RST 32'h00000000
`define RSW_WD_INTERVAL_RST 32'hffffffff
`define RSW_AUX_DIR_RST 16'h0000
`endif

/* logic/rsw_watchdog.v */
// rsw_watchdog.v: emergency shutdown, software watchdog, relay pattern control, aux i/o
// assumes pins arrive asynchronous; register master follows the plain strobe port
//
// Functional notes
// - star trigger driver stays off after reset until software enables routing.
// - each of eight aux lines is input, driven output or tri-stated.
// - aux read returns the sampled pin level even when driven.
// - shutdown request pin is active low and triggers when enabled.
// - software picks shutdown source: request pin or a trigger bus line.
// - shutdown and watchdog are disabled after reset until enabled.
// - enabled shutdown trigger enters shutdown and drives the preset pattern.
// - preset pattern resets to all off and is software writable.
// - a running scan halts at once on shutdown entry.
// - direct updates are ignored while in shutdown.
// - recovery leaves shutdown once no trigger remains, keeps the pattern, rewinds the scan pointer.
// - aux line two low acts like the shutdown request pin.
// - onboard 32-bit watchdog counter with programmable interval.
// - software picks watchdog source: local counter or trigger bus line.
// - missed kick raises overflow and drives the preset pattern.
// - scan advances entries, stops at end in one-time mode or on abort.
`timescale 1ns/10ps
`include "rsw_defs.vh"

module rsw_watchdog #(
	parameter RELAYS = 32,
	parameter SCAN_DEPTH = 1024,
	parameter SCAN_AW = 10
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// front panel shutdown request
	input wire shutdown_request_n,
	// trigger bus (open drain, oe low drives low)
	input wire [7:0] trig_bus_in,
	output wire [7:0] trig_bus_out,
	output wire [7:0] trig_bus_oe_n,
	// star trigger output
	output reg star_trig_out,
	output wire star_trig_oe_n,
	// auxiliary digital i/o
	input wire [7:0] aux_in,
	output reg [7:0] aux_out,
	output wire [7:0] aux_oe_n,
	// relay drivers and status
	output reg [RELAYS-1:0] relay_out,
	output reg wd_overflow,
	output wire shutdown_active
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_SCAN = 3'b010;
	localparam ST_SHDN = 3'b100;

	reg [31:0] ctrl_reg;
	reg [RELAYS-1:0] preset_reg;
	reg [31:0] wd_interval_reg;
	reg [31:0] wd_count_reg;
	reg [15:0] aux_dir_reg;
	reg [7:0] aux_val_reg;
	reg star_en_reg;
	reg [SCAN_AW-1:0] scan_len_reg;
	reg [SCAN_AW-1:0] scan_ptr_reg;
	reg [SCAN_AW-1:0] scan_waddr_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [RELAYS-1:0] relay_next;
	reg [SCAN_AW-1:0] scan_ptr_next;
	reg [RELAYS-1:0] scan_mem [0:SCAN_DEPTH-1];
	reg [8:0] shdn_s1_reg;
	reg [8:0] shdn_s2_reg;
	reg [7:0] tb_s1_reg;
	reg [7:0] tb_s2_reg;

	function [7:0] one_hot8;
		input [2:0] idx;
		begin
			one_hot8 = 8'h01 << idx;
		end
	endfunction

	// register write decode shared by the command, pattern and scan paths
	function wr_hit;
		input strobe;
		input [3:0] addr;
		input [3:0] want;
		begin
			wr_hit = strobe && (addr == want);
		end
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// preset high so an idle pin never reads as a request straight after reset
	always @(posedge clk) begin
		if (!reset_n) begin
			shdn_s1_reg <= 9'h1ff;
			shdn_s2_reg <= 9'h1ff;
			tb_s1_reg <= 8'hff;
			tb_s2_reg <= 8'hff;
		end else begin
			shdn_s1_reg <= {shutdown_request_n, aux_in};
			shdn_s2_reg <= shdn_s1_reg;
			tb_s1_reg <= trig_bus_in;
			tb_s2_reg <= tb_s1_reg;
		end
	end

	wire [7:0] aux_sync = shdn_s2_reg[7:0];
	wire req_n_sync = shdn_s2_reg[8];
	wire wr_cmd = wr_hit(reg_wr, reg_addr, `RSW_A_CMD);
	wire wr_direct = wr_hit(reg_wr, reg_addr, `RSW_A_DIRECT);
	wire wr_scan_data = wr_hit(reg_wr, reg_addr, `RSW_A_SCAN_DATA);
	wire kick = wr_cmd && reg_wdata[`RSW_K_WD_KICK];
	wire recover = wr_cmd && reg_wdata[`RSW_K_RECOVER];
	wire scan_start = wr_cmd && reg_wdata[`RSW_K_SCAN_START];
	wire scan_abort = wr_cmd && reg_wdata[`RSW_K_SCAN_ABORT];

	// ----------------------------------------
	// trigger detection
	// ----------------------------------------
	// the request pin and aux line two are separate inputs, synchronised together; either low counts
	wire aux_line_two = aux_sync[2];
	wire pin_low = !req_n_sync || !aux_line_two;
	wire [2:0] shdn_line = ctrl_reg[`RSW_C_SHDN_TLO+2:`RSW_C_SHDN_TLO];
	wire [2:0] wd_line = ctrl_reg[`RSW_C_WD_TLO+2:`RSW_C_WD_TLO];
	wire [2:0] wd_oline = ctrl_reg[`RSW_C_WD_OLO+2:`RSW_C_WD_OLO];
	// trigger bus lines are active low; a released line reads high through its pull-up
	wire bus_shdn = !(|(tb_s2_reg & one_hot8(shdn_line)));
	wire shdn_src = ctrl_reg[`RSW_C_SHDN_SRC] ? bus_shdn : pin_low;
	wire shdn_trig = ctrl_reg[`RSW_C_SHDN_EN] && shdn_src;
	wire local_ovf = (wd_count_reg == 32'h00000000) && !kick;
	wire bus_ovf = !(|(tb_s2_reg & one_hot8(wd_line)));
	wire ovf_src = ctrl_reg[`RSW_C_WD_SRC] ? bus_ovf : local_ovf;
	wire wd_trig = ctrl_reg[`RSW_C_WD_EN] && ovf_src;
	wire safe_trig = shdn_trig || wd_trig;

	// ----------------------------------------
	// watchdog counter
	// ----------------------------------------
	always @(posedge clk) begin
		if (!reset_n) begin
			wd_count_reg <= `RSW_WD_INTERVAL_RST;
			wd_overflow <= 1'b0;
		end else begin
			// reload while disabled so that enabling starts a full interval
			if (kick || !ctrl_reg[`RSW_C_WD_EN])
				wd_count_reg <= wd_interval_reg;
			else if (wd_count_reg != 32'h00000000)
				wd_count_reg <= wd_count_reg - 32'h00000001;
			// a kick alone never clears a latched overflow
			if (!ctrl_reg[`RSW_C_WD_EN])
				wd_overflow <= 1'b0;
			else if (wd_trig)
				wd_overflow <= 1'b1;
			else if (recover)
				wd_overflow <= 1'b0;
		end
	end

	// overflow driven onto a bus line as open-drain low when routed
	wire wd_drive = ctrl_reg[`RSW_C_WD_DRIVE] && wd_overflow;
	assign trig_bus_out = 8'h00;
	assign trig_bus_oe_n = wd_drive ? ~one_hot8(wd_oline) : 8'hff;

	// ----------------------------------------
	// mode state machine
	// ----------------------------------------
	wire scan_last = (scan_ptr_reg == scan_len_reg);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (safe_trig)
					state_next = ST_SHDN;
				else if (scan_start && ctrl_reg[`RSW_C_AUTO])
					state_next = ST_SCAN;
			end
			ST_SCAN: begin
				if (safe_trig)
					state_next = ST_SHDN;
				else if (scan_abort || (scan_last && !ctrl_reg[`RSW_C_CYCLIC]))
					state_next = ST_IDLE;
			end
			ST_SHDN: begin
				// a trigger still present keeps shutdown even across a recovery
				if (recover && !safe_trig)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	assign shutdown_active = state_reg[2];

	// ----------------------------------------
	// relay pattern and scan pointer
	// ----------------------------------------
	wire direct_ok = wr_direct && state_reg == ST_IDLE && state_next == ST_IDLE
		&& !ctrl_reg[`RSW_C_AUTO];

	// shutdown entry outranks a scan step, which outranks a direct write
	always @* begin
		relay_next = relay_out;
		if (state_next == ST_SHDN && state_reg != ST_SHDN)
			relay_next = preset_reg;
		else if (state_reg == ST_SCAN && !scan_abort)
			relay_next = scan_mem[scan_ptr_reg];
		else if (direct_ok)
			relay_next = reg_wdata[RELAYS-1:0];
	end

	// the last entry is still shown on the cycle a one-time scan ends
	always @* begin
		scan_ptr_next = scan_ptr_reg;
		if (state_reg == ST_SHDN && recover)
			scan_ptr_next = {SCAN_AW{1'b0}};
		else if (state_reg == ST_IDLE && state_next == ST_SCAN)
			scan_ptr_next = {SCAN_AW{1'b0}};
		else if (state_reg == ST_SCAN && state_next == ST_SCAN)
			scan_ptr_next = scan_last ? {SCAN_AW{1'b0}} : scan_ptr_reg + 1'b1;
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			scan_ptr_reg <= {SCAN_AW{1'b0}};
			relay_out <= {RELAYS{1'b0}};
		end else begin
			state_reg <= state_next;
			relay_out <= relay_next;
			scan_ptr_reg <= scan_ptr_next;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (!reset_n) begin
			ctrl_reg <= 32'h00000000;
			preset_reg <= `RSW_PRESET_RST;
			wd_interval_reg <= `RSW_WD_INTERVAL_RST;
			aux_dir_reg <= `RSW_AUX_DIR_RST;
			aux_val_reg <= 8'h00;
			star_en_reg <= 1'b0;
			scan_len_reg <= {SCAN_AW{1'b0}};
			scan_waddr_reg <= {SCAN_AW{1'b0}};
		end else if (reg_wr) begin
			case (reg_addr)
				`RSW_A_CTRL: ctrl_reg <= reg_wdata;
				`RSW_A_PRESET: preset_reg <= reg_wdata[RELAYS-1:0];
				`RSW_A_WD_INTERVAL: wd_interval_reg <= reg_wdata;
				`RSW_A_AUX_DIR: aux_dir_reg <= reg_wdata[15:0];
				`RSW_A_AUX_OUT: aux_val_reg <= reg_wdata[7:0];
				`RSW_A_STAR: star_en_reg <= reg_wdata[`RSW_S_EN];
				`RSW_A_SCAN_LEN: scan_len_reg <= reg_wdata[SCAN_AW-1:0];
				`RSW_A_SCAN_DATA: scan_waddr_reg <= scan_waddr_reg + 1'b1;
				`RSW_A_CMD: begin
					if (reg_wdata[`RSW_K_SCAN_ADDR_CLR])
						scan_waddr_reg <= {SCAN_AW{1'b0}};
				end
				default: ;
			endcase
		end
	end

	// scan memory has no reset, it is loaded by software before a start
	always @(posedge clk) begin
		if (wr_scan_data)
			scan_mem[scan_waddr_reg] <= reg_wdata[RELAYS-1:0];
	end

	// ----------------------------------------
	// aux and star trigger pins
	// ----------------------------------------
	// two dir bits per line: 00 input, 01 driven output, 1x tri-stated
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_aux
			assign aux_oe_n[gi] = !(aux_dir_reg[2*gi+1:2*gi] == 2'b01);
		end
	endgenerate

	always @(posedge clk) begin
		if (!reset_n) begin
			aux_out <= 8'h00;
			star_trig_out <= 1'b0;
		end else begin
			aux_out <= aux_val_reg;
			star_trig_out <= wd_overflow || shutdown_active;
		end
	end

	assign star_trig_oe_n = !star_en_reg;

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// status: scanning, overflow latched, in shutdown, live shutdown and watchdog triggers
	wire [31:0] status_word = {
		27'h0000000,
		state_reg[1],
		wd_overflow,
		shutdown_active,
		shdn_trig,
		wd_trig
	};

	// read data stand one cycle only, then fall back to zero
	always @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`RSW_A_CTRL: reg_rdata <= ctrl_reg;
				`RSW_A_PRESET: reg_rdata <= preset_reg;
				`RSW_A_WD_INTERVAL: reg_rdata <= wd_interval_reg;
				`RSW_A_AUX_DIR: reg_rdata <= {16'h0000, aux_dir_reg};
				`RSW_A_AUX_OUT: reg_rdata <= {24'h000000, aux_val_reg};
				`RSW_A_AUX_IN: reg_rdata <= {24'h000000, aux_sync};
				`RSW_A_STATUS: reg_rdata <= status_word;
				`RSW_A_DIRECT: reg_rdata <= relay_out;
				`RSW_A_SCAN_LEN: reg_rdata <= {{(32-SCAN_AW){1'b0}}, scan_ptr_reg};
				`RSW_A_WD_COUNT: reg_rdata <= wd_count_reg;
				`RSW_A_STAR: reg_rdata <= {31'h00000000, star_en_reg};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule // rsw_watchdog

/* sim/rsw_watchdog_chk.sv */
// rsw_watchdog_chk.sv: port-level assertions for the relay safety watchdog
// assumes a bind onto rsw_watchdog; it watches that module's ports only
`timescale 1ns/10ps
module rsw_watchdog_chk #(
	parameter RELAYS = 32
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// pins seen by the design
	input wire shutdown_request_n,
	input wire [7:0] trig_bus_in,
	input wire [7:0] aux_in,
	// design outputs
	input wire [7:0] trig_bus_out,
	input wire [7:0] trig_bus_oe_n,
	input wire star_trig_out,
	input wire star_trig_oe_n,
	input wire [7:0] aux_oe_n,
	input wire [RELAYS-1:0] relay_out,
	input wire wd_overflow,
	input wire shutdown_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_drivers_idle: assert property ($past(!reset_n) |-> star_trig_oe_n && aux_oe_n == 8'hff)
		else $error("driver enabled straight after reset");
	chk_star_follow: assert property (star_trig_out == $past(wd_overflow | shutdown_active))
		else $error("star output does not follow shutdown");
	chk_shdn_frozen: assert property (shutdown_active && $past(shutdown_active) |-> $stable(relay_out))
		else $error("relay pattern moved in shutdown");
	chk_recover_keep: assert property ($fell(shutdown_active) |-> $stable(relay_out))
		else $error("relay pattern moved on recovery");
	chk_ovf_enters: assert property ($rose(wd_overflow) |-> ##[0:2] shutdown_active)
		else $error("overflow without shutdown");
	chk_bus_quiet: assert property (!wd_overflow |-> trig_bus_oe_n == 8'hff)
		else $error("trigger bus driven without overflow");
	chk_bus_data_low: assert property (trig_bus_out == 8'h00)
		else $error("trigger bus data not low");
	chk_shdn_cause: assert property ($rose(shutdown_active) |-> wd_overflow || $past(wd_overflow)
		|| !$past(shutdown_request_n, 3) || !$past(aux_in[2], 3) || $past(trig_bus_in, 3) != 8'hff)
		else $error("shutdown without a trigger");
endmodule // rsw_watchdog_chk

/* sim/rsw_far_side.sv */
// rsw_far_side.sv: shutdown button, trigger bus and aux pins around the watchdog
// assumes every press or pull is commanded by the bench; all lines have pull-ups
`timescale 1ns/10ps
module rsw_far_side (
	// bench commands
	input wire press,
	input wire [7:0] bus_pull,
	input wire [7:0] aux_pull,
	// design side
	input wire [7:0] trig_bus_oe_n,
	input wire [7:0] aux_out,
	input wire [7:0] aux_oe_n,
	output wire shutdown_request_n,
	output wire [7:0] trig_bus_in,
	output wire [7:0] aux_in
);
	// button pulls the pin low; released it floats back up
	assign shutdown_request_n = ~press;
	// wired-and bus: any low driver wins over the pull-up
	assign trig_bus_in = ~(bus_pull | ~trig_bus_oe_n);
	// outside pull overpowers the module; only done when the bench asks
	assign aux_in = ~aux_pull & (aux_oe_n | aux_out);
endmodule // rsw_far_side

/* sim/tb.sv */
// tb.sv: self-checking bench for the relay safety watchdog
// assumes rsw_watchdog with 32 relays and the far-side model rsw_far_side
`timescale 1ns/10ps
`include "rsw_defs.vh"
module tb;
	logic clk, reset_n, reg_wr, reg_rd, press, shutdown_request_n;
	logic star_trig_out, star_trig_oe_n, wd_overflow, shutdown_active;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_val, relay_out;
	logic [7:0] bus_pull, aux_pull, trig_bus_in, trig_bus_out, trig_bus_oe_n;
	logic [7:0] aux_in, aux_out, aux_oe_n;
	int error_cnt = 0;
	int num_checks = 0;
	rsw_watchdog rsw_watchdog_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.shutdown_request_n(shutdown_request_n), .trig_bus_in(trig_bus_in),
		.trig_bus_out(trig_bus_out), .trig_bus_oe_n(trig_bus_oe_n), .star_trig_out(star_trig_out),
		.star_trig_oe_n(star_trig_oe_n), .aux_in(aux_in), .aux_out(aux_out), .aux_oe_n(aux_oe_n),
		.relay_out(relay_out), .wd_overflow(wd_overflow), .shutdown_active(shutdown_active));
	rsw_far_side rsw_far_side_inst (.press(press), .bus_pull(bus_pull), .aux_pull(aux_pull),
		.trig_bus_oe_n(trig_bus_oe_n), .aux_out(aux_out), .aux_oe_n(aux_oe_n),
		.shutdown_request_n(shutdown_request_n), .trig_bus_in(trig_bus_in), .aux_in(aux_in));
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic wait_for(input bit ovf, input int lim);
		int i;
		#1;
		for (i = 0; i < lim; i++) begin
			if ((ovf ? wd_overflow : shutdown_active) === 1'b1) break;
			cyc(1);
		end
		if (i == lim) begin
			error_cnt++;
			wrap_up();
		end
	endtask
	task automatic t_reset;
		chk({31'h0, star_trig_oe_n}, 32'h1);
		rd(`RSW_A_CTRL, 32'h0);
		rd(`RSW_A_PRESET, `RSW_PRESET_RST);
		rd(`RSW_A_WD_INTERVAL, `RSW_WD_INTERVAL_RST);
		wr(`RSW_A_STAR, 32'h1);
		cyc(1);
		chk({31'h0, star_trig_oe_n}, 32'h0);
	endtask
	task automatic t_pin;
		wr(`RSW_A_DIRECT, 32'hf0);
		rd(`RSW_A_DIRECT, 32'hf0);
		press <= 1'b1;
		cyc(6);
		chk({31'h0, shutdown_active}, 32'h0);
		press <= 1'b0;
		wr(`RSW_A_PRESET, 32'ha5a5);
		wr(`RSW_A_CTRL, 32'h1);
		press <= 1'b1;
		wait_for(0, 10);
		chk(relay_out, 32'ha5a5);
		wr(`RSW_A_DIRECT, 32'hff);
		rd(`RSW_A_DIRECT, 32'ha5a5);
		press <= 1'b0;
		cyc(4);
		wr(`RSW_A_CMD, 32'h2);
		cyc(2);
		chk({31'h0, shutdown_active}, 32'h0);
		chk(relay_out, 32'ha5a5);
	endtask
	task automatic t_aux;
		aux_pull <= 8'h04;
		wait_for(0, 10);
		chk(relay_out, 32'ha5a5);
		aux_pull <= 8'h00;
		cyc(4);
		wr(`RSW_A_CMD, 32'h2);
		wr(`RSW_A_CTRL, 32'h503);
		bus_pull <= 8'h20;
		wait_for(0, 10);
		chk({31'h0, shutdown_active}, 32'h1);
		bus_pull <= 8'h00;
		wr(`RSW_A_CTRL, 32'h0);
		wr(`RSW_A_CMD, 32'h2);
		wr(`RSW_A_AUX_DIR, 32'h21);
		wr(`RSW_A_AUX_OUT, 32'h1);
		cyc(2);
		chk({24'h0, aux_oe_n}, 32'hfe);
		chk({24'h0, aux_out}, 32'h01);
		aux_pull <= 8'h01;
		cyc(3);
		rd(`RSW_A_AUX_IN, 32'hfe);
		aux_pull <= 8'h00;
	endtask
	task automatic t_wd;
		wr(`RSW_A_WD_INTERVAL, 32'h28);
		wr(`RSW_A_CTRL, 32'h30044);
		repeat (4) begin
			cyc(20);
			wr(`RSW_A_CMD, 32'h1);
		end
		chk({31'h0, wd_overflow}, 32'h0);
		cyc(38);
		chk({31'h0, wd_overflow}, 32'h0);
		wait_for(1, 10);
		cyc(2);
		chk(relay_out, 32'ha5a5);
		chk({24'h0, trig_bus_oe_n}, 32'hf7);
		wr(`RSW_A_CTRL, 32'h200c);
		wr(`RSW_A_CMD, 32'h2);
		cyc(1);
		chk({31'h0, wd_overflow}, 32'h0);
		bus_pull <= 8'h04;
		wait_for(1, 10);
		chk({31'h0, wd_overflow}, 32'h1);
		bus_pull <= 8'h00;
		wr(`RSW_A_CTRL, 32'h0);
		wr(`RSW_A_CMD, 32'h2);
	endtask
	task automatic t_scan;
		wr(`RSW_A_SCAN_LEN, 32'h2);
		wr(`RSW_A_CMD, 32'h10);
		wr(`RSW_A_SCAN_DATA, 32'h11);
		wr(`RSW_A_SCAN_DATA, 32'h22);
		wr(`RSW_A_SCAN_DATA, 32'h33);
		wr(`RSW_A_CTRL, 32'h10);
		wr(`RSW_A_CMD, 32'h4);
		cyc(10);
		chk(relay_out, 32'h33);
		rd(`RSW_A_STATUS, 32'h0);
		wr(`RSW_A_CTRL, 32'h31);
		wr(`RSW_A_CMD, 32'h4);
		press <= 1'b1;
		wait_for(0, 10);
		cyc(4);
		chk(relay_out, 32'ha5a5);
		press <= 1'b0;
		cyc(4);
		rd(`RSW_A_SCAN_LEN, 32'h2);
		wr(`RSW_A_CMD, 32'h2);
		rd(`RSW_A_SCAN_LEN, 32'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		{reg_wr, reg_rd, press} = 3'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		bus_pull = 8'h00;
		aux_pull = 8'h00;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_pin();
		t_aux();
		t_wd();
		t_scan();
		wrap_up();
	end
endmodule // tb
bind rsw_watchdog rsw_watchdog_chk #(.RELAYS(RELAYS)) rsw_watchdog_chk_inst (.clk(clk),
	.reset_n(reset_n), .shutdown_request_n(shutdown_request_n), .trig_bus_in(trig_bus_in),
	.aux_in(aux_in), .trig_bus_out(trig_bus_out), .trig_bus_oe_n(trig_bus_oe_n),
	.star_trig_out(star_trig_out), .star_trig_oe_n(star_trig_oe_n), .aux_oe_n(aux_oe_n),
	.relay_out(relay_out), .wd_overflow(wd_overflow), .shutdown_active(shutdown_active));
